// ### logic/eprom_host_pkg.sv
// Constants, command codes and controller states for the EPROM programming host
package eprom_host_pkg;
   // ==========================================================
   // Geometry of the memory
   localparam int ADDR_W = 17;
   localparam int DATA_W = 8;
   localparam int ID_LINE_BIT = 9;
   localparam int ID_SEL_BIT = 0;
   localparam logic [16:0] ID_ADDR_BASE = 17'h00200;
   localparam logic [7:0] ERASED_BYTE = 8'hFF;

   // ==========================================================
   // Timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int PULSE_US = 100;
   localparam int PULSE_CYCLES = (PULSE_US * 1000) / CLK_PERIOD_NS;
   localparam int T_ACCESS_NS = 150;
   localparam int ACCESS_CYCLES = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int T_SETUP_NS = 2000;
   localparam int SETUP_CYCLES = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int MAX_PULSES = 25;
   localparam int TIMER_W = 12;
   localparam int PCNT_W = 5;

   // ==========================================================
   // Commands and states
   typedef enum logic [1:0] {
      OP_READ = 2'h0,
      OP_IDENT = 2'h1,
      OP_PROGRAM = 2'h2
   } host_op_e;

   typedef enum logic [10:0] {
      ST_IDLE = 11'h001,
      ST_FETCH = 11'h002,
      ST_SETUP = 11'h004,
      ST_PULSE = 11'h008,
      ST_VWAIT = 11'h010,
      ST_VSAMPLE = 11'h020,
      ST_CFETCH = 11'h040,
      ST_CWAIT = 11'h080,
      ST_CSAMPLE = 11'h100,
      ST_RWAIT = 11'h200,
      ST_RDONE = 11'h400
   } host_state_e;
endpackage

// ### logic/eprom_host.sv
// Pin-level host that reads, identifies and fast-programs a 128K x 8 UV EPROM
// Contract
// - Host drives all eight data bits in parallel while programming.
// - Program mode: select low, gate high, strobe low, supply raised; data is input.
// - Hold address and data stable, then one 100 us low strobe pulse.
// - On mismatch pulse again and recheck, at most 25 pulses per address.
// - Repeat pulse-and-verify for each address in turn up to the last.
// - After programming, read back every address with supplies at read level.
// - Parallel devices share all inputs except select and output gate.
// - Supply high, strobe low: a low select pulse programs that device. The host instead holds select low and pulses the strobe low.
// - Verify: select and gate low, strobe high, supply high; device drives byte.
// - Identify voltage on identify line; lowest address bit picks identifier byte.
// - During identify all other address lines are held low.
// - Decode select per device; tie output gates to the system read strobe.
module eprom_host
   import eprom_host_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Command port
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [1:0] cmd_op,
   input wire logic [ADDR_W-1:0] cmd_addr,
   input wire logic [ADDR_W-1:0] cmd_last,
   // Byte stream for programming and final check
   output logic data_need,
   input wire logic data_valid,
   input wire logic [DATA_W-1:0] data_byte,
   // Results
   output logic done,
   output logic fail,
   output logic [ADDR_W-1:0] fail_addr,
   output logic [DATA_W-1:0] rd_byte,
   output logic id_parity_ok,
   output logic [PCNT_W-1:0] pulses_used,
   // Memory pins
   output logic [ADDR_W-1:0] word_address_bus,
   output logic [DATA_W-1:0] byte_data_pins_out,
   input wire logic [DATA_W-1:0] byte_data_pins_in,
   output logic byte_data_pins_oe_n,
   output logic chip_select_n,
   output logic output_gate_n,
   output logic program_strobe_n,
   output logic program_supply_high,
   output logic identify_high_voltage
);
   // ==========================================================
   // Helpers
   function automatic logic [ADDR_W-1:0] addr_inc(input logic [ADDR_W-1:0] a);
      addr_inc = ADDR_W'(a + 17'h00001);
   endfunction

   // ==========================================================
   // State
   host_state_e state_ff, nxt_state;
   host_op_e op_ff, nxt_op;
   logic [ADDR_W-1:0] addr_ff, nxt_addr, start_ff, nxt_start, last_ff, nxt_last;
   logic [DATA_W-1:0] data_ff, nxt_data, rd_ff, nxt_rd;
   logic [TIMER_W-1:0] timer_ff, nxt_timer;
   logic [PCNT_W-1:0] pcnt_ff, nxt_pcnt;
   logic done_ff, nxt_done, fail_ff, nxt_fail, par_ff, nxt_par;
   logic [ADDR_W-1:0] faddr_ff, nxt_faddr;

   wire timer_zero = (timer_ff == '0);
   wire byte_match = (byte_data_pins_in == data_ff);
   wire at_last = (addr_ff == last_ff);
   wire in_prog = (state_ff == ST_SETUP) || (state_ff == ST_PULSE) ||
                  (state_ff == ST_VWAIT) || (state_ff == ST_VSAMPLE) || (state_ff == ST_FETCH);
   wire in_read = (state_ff == ST_VWAIT) || (state_ff == ST_VSAMPLE) ||
                  (state_ff == ST_CWAIT) || (state_ff == ST_CSAMPLE) ||
                  (state_ff == ST_RWAIT) || (state_ff == ST_RDONE);
   wire deselect = (state_ff == ST_IDLE) || (state_ff == ST_FETCH) || (state_ff == ST_CFETCH);

   // ==========================================================
   // Sequencer
   always_comb begin
      nxt_state = state_ff;
      nxt_op = op_ff;
      nxt_addr = addr_ff;
      nxt_start = start_ff;
      nxt_last = last_ff;
      nxt_data = data_ff;
      nxt_rd = rd_ff;
      nxt_timer = timer_zero ? timer_ff : TIMER_W'(timer_ff - 12'h001);
      nxt_pcnt = pcnt_ff;
      nxt_done = 1'b0;
      nxt_fail = fail_ff;
      nxt_par = par_ff;
      nxt_faddr = faddr_ff;
      case (state_ff)
         ST_IDLE: begin
            if (cmd_valid) begin
               nxt_op = host_op_e'(cmd_op);
               nxt_addr = cmd_addr;
               nxt_start = cmd_addr;
               nxt_last = cmd_last;
               nxt_fail = 1'b0;
               nxt_timer = TIMER_W'(ACCESS_CYCLES - 1);
               nxt_state = ST_RWAIT;
               if (host_op_e'(cmd_op) == OP_IDENT) begin
                  // Only the identify line and the byte select stay set
                  nxt_addr = ID_ADDR_BASE | {16'h0000, cmd_addr[ID_SEL_BIT]};
               end else if (host_op_e'(cmd_op) == OP_PROGRAM) begin
                  nxt_state = ST_FETCH;
               end
            end
         end
         ST_FETCH: begin
            if (data_valid) begin
               // Whole byte latched once, held on all eight pins
               nxt_data = data_byte;
               nxt_pcnt = '0;
               nxt_timer = TIMER_W'(SETUP_CYCLES - 1);
               nxt_state = ST_SETUP;
            end
         end
         ST_SETUP: begin
            if (timer_zero) begin
               nxt_timer = TIMER_W'(PULSE_CYCLES - 1);
               nxt_pcnt = PCNT_W'(pcnt_ff + 5'h01);
               nxt_state = ST_PULSE;
            end
         end
         ST_PULSE: begin
            // Exact pulse width
            if (timer_zero) begin
               nxt_timer = TIMER_W'(ACCESS_CYCLES - 1);
               nxt_state = ST_VWAIT;
            end
         end
         ST_VWAIT: nxt_state = timer_zero ? ST_VSAMPLE : ST_VWAIT;
         ST_VSAMPLE: begin
            if (byte_match) begin
               // Walk addresses in order, then start the read-level pass
               nxt_addr = at_last ? start_ff : addr_inc(addr_ff);
               nxt_state = at_last ? ST_CFETCH : ST_FETCH;
            end else if (pcnt_ff == PCNT_W'(MAX_PULSES)) begin
               // Give up on this address after the last allowed pulse
               nxt_fail = 1'b1;
               nxt_faddr = addr_ff;
               nxt_done = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_timer = TIMER_W'(SETUP_CYCLES - 1);
               nxt_state = ST_SETUP;
            end
         end
         ST_CFETCH: begin
            if (data_valid) begin
               nxt_data = data_byte;
               nxt_timer = TIMER_W'(ACCESS_CYCLES - 1);
               nxt_state = ST_CWAIT;
            end
         end
         ST_CWAIT: nxt_state = timer_zero ? ST_CSAMPLE : ST_CWAIT;
         ST_CSAMPLE: begin
            // Every address compared again at read levels
            if (!byte_match) begin
               nxt_fail = 1'b1;
               nxt_faddr = addr_ff;
               nxt_done = 1'b1;
               nxt_state = ST_IDLE;
            end else if (at_last) begin
               nxt_done = 1'b1;
               nxt_state = ST_IDLE;
            end else begin
               nxt_addr = addr_inc(addr_ff);
               nxt_state = ST_CFETCH;
            end
         end
         ST_RWAIT: nxt_state = timer_zero ? ST_RDONE : ST_RWAIT;
         ST_RDONE: begin
            nxt_rd = byte_data_pins_in;
            // Identifier bytes should show odd parity
            nxt_par = ^byte_data_pins_in;
            nxt_done = 1'b1;
            nxt_state = ST_IDLE;
         end
         default: nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= ST_IDLE;
         op_ff <= OP_READ;
         addr_ff <= '0;
         start_ff <= '0;
         last_ff <= '0;
         data_ff <= ERASED_BYTE;
         rd_ff <= '0;
         timer_ff <= '0;
         pcnt_ff <= '0;
         done_ff <= 1'b0;
         fail_ff <= 1'b0;
         par_ff <= 1'b0;
         faddr_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         op_ff <= nxt_op;
         addr_ff <= nxt_addr;
         start_ff <= nxt_start;
         last_ff <= nxt_last;
         data_ff <= nxt_data;
         rd_ff <= nxt_rd;
         timer_ff <= nxt_timer;
         pcnt_ff <= nxt_pcnt;
         done_ff <= nxt_done;
         fail_ff <= nxt_fail;
         par_ff <= nxt_par;
         faddr_ff <= nxt_faddr;
      end
   end

   // ==========================================================
   // Pin decode from one-hot state, so no pin can glitch between modes
   assign word_address_bus = addr_ff;
   assign byte_data_pins_out = data_ff;
   // Drive data only with the gate high, never against the device
   assign byte_data_pins_oe_n = !((state_ff == ST_SETUP) || (state_ff == ST_PULSE));
   // Own select and gate per device; everything else may be shared
   assign chip_select_n = deselect;
   assign output_gate_n = !in_read;
   // Strobe low only with select low and supply raised
   assign program_strobe_n = (state_ff != ST_PULSE);
   // High voltages as plain qualifiers
   assign program_supply_high = in_prog;
   assign identify_high_voltage = (op_ff == OP_IDENT) &&
                                  ((state_ff == ST_RWAIT) || (state_ff == ST_RDONE));
   assign cmd_ready = (state_ff == ST_IDLE);
   assign data_need = (state_ff == ST_FETCH) || (state_ff == ST_CFETCH);
   assign done = done_ff;
   assign fail = fail_ff;
   assign fail_addr = faddr_ff;
   assign rd_byte = rd_ff;
   assign id_parity_ok = par_ff;
   assign pulses_used = pcnt_ff;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   logic [TIMER_W-1:0] low_cnt_ff;
   always_ff @(posedge clk) begin
      if (reset) begin
         low_cnt_ff <= '0;
      end else begin
         low_cnt_ff <= program_strobe_n ? '0 : TIMER_W'(low_cnt_ff + 12'h001);
      end
   end
   sequence pulse_end_s;
      $rose(program_strobe_n);
   endsequence
   sequence verify_read_s;
      !chip_select_n && !output_gate_n && program_strobe_n && program_supply_high;
   endsequence

   pulse_width_a: assert property (pulse_end_s |-> low_cnt_ff == TIMER_W'(PULSE_CYCLES))
      else $error("program pulse width wrong");
   pulse_stable_a: assert property (!program_strobe_n && !$past(program_strobe_n) |->
      $stable(word_address_bus) && $stable(byte_data_pins_out))
      else $error("address or data moved during pulse");
   program_mode_a: assert property (!program_strobe_n |->
      !chip_select_n && output_gate_n && program_supply_high && !byte_data_pins_oe_n)
      else $error("pulse outside program mode");
   drive_gate_a: assert property (!byte_data_pins_oe_n |-> output_gate_n)
      else $error("host drives data with gate low");
   verify_after_pulse_a: assert property (pulse_end_s |-> verify_read_s [*5])
      else $error("verify read not set up after pulse");
   pulse_limit_a: assert property (pcnt_ff <= PCNT_W'(MAX_PULSES))
      else $error("too many pulses for one address");
   addr_step_a: assert property (
      $past(state_ff == ST_VSAMPLE) && state_ff == ST_FETCH |->
      word_address_bus == addr_inc($past(word_address_bus)))
      else $error("address not advanced by one");
   check_levels_a: assert property (state_ff == ST_CSAMPLE |->
      !program_supply_high && !identify_high_voltage && !output_gate_n)
      else $error("final check not at read levels");
   ident_mode_a: assert property (identify_high_voltage |->
      !chip_select_n && !output_gate_n && !program_supply_high &&
      word_address_bus[ID_LINE_BIT])
      else $error("identify mode pins wrong");
   ident_addr_a: assert property (identify_high_voltage |->
      (word_address_bus & ~(ID_ADDR_BASE | 17'h00001)) == '0)
      else $error("stray address line high in identify");
endmodule // eprom_host

// ### dv/eprom_device_model.sv
// Behavioural model of the 128K x 8 EPROM driven by the host
module eprom_device_model #(
   parameter logic [16:0] SLOW_ADDR = 17'h1FFFE,
   parameter int SLOW_PULSES = 3,
   // Arbitrary identifier values, each of odd parity
   parameter logic [7:0] MAKER_CODE = 8'h4A,
   parameter logic [7:0] DEVICE_CODE = 8'h31
) (
   // Clock
   input wire logic clk,
   // Pins
   input wire logic [16:0] addr,
   input wire logic [7:0] din,
   input wire logic cs_n,
   input wire logic og_n,
   input wire logic strobe_n,
   input wire logic vpp_high,
   input wire logic id_high,
   output logic [7:0] dout,
   output logic dout_en,
   output logic misuse
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Array
   logic [7:0] mem [0:131071];
   logic prog_ff = 1'h0;
   int slow_cnt = 0;
   logic misuse_ff = 1'h0;
   logic [7:0] hold_q = 8'hFF;
   logic [16:0] hold_a = 17'h0;
   wire prog_on = !cs_n && og_n && !strobe_n && vpp_high;
   initial begin
      for (int i = 0; i < 131072; i++) begin
         mem[i] = 8'hFF;
      end
   end
   // ==========================================================
   // Programming
   // Byte latched while the pulse stands, written as it ends: by then the pins
   // already carry the verify read. One slow cell needs several pulses to take
   always @(posedge clk) begin
      prog_ff <= (prog_on === 1'h1);
      if (prog_on === 1'h1) begin
         hold_q <= din;
         hold_a <= addr;
      end
      if (prog_ff && prog_on !== 1'h1) begin
         if (hold_a != SLOW_ADDR || slow_cnt >= SLOW_PULSES - 1) begin
            mem[hold_a] <= mem[hold_a] & hold_q;
         end
         if (hold_a == SLOW_ADDR) begin
            slow_cnt <= slow_cnt + 1;
         end
      end
      if (id_high === 1'h1 && ((addr & ~17'h00201) != 17'h0 || vpp_high)) begin
         misuse_ff <= 1'h1;
      end
   end
   assign misuse = misuse_ff;
   // ==========================================================
   // Outputs
   assign dout_en = !cs_n && !og_n;
   assign dout = !id_high ? mem[addr] :
      (addr[0] ? DEVICE_CODE : MAKER_CODE);
endmodule // eprom_device_model

// ### dv/eprom_host_bench.sv
// Self-checking bench for the EPROM programming host
module eprom_host_bench
   import eprom_host_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   // Arbitrary identifier values, each of odd parity
   localparam logic [7:0] MAKER = 8'h4A;
   localparam logic [7:0] DEVICE = 8'h31;
   logic clk = 1'h0, reset = 1'h1, cmd_valid = 1'h0, data_valid = 1'h0;
   logic [1:0] cmd_op = 2'h0;
   logic [16:0] cmd_addr = 17'h0, cmd_last = 17'h0;
   logic [7:0] data_byte = 8'h0, last_ff = 8'h0;
   logic [7:0] want [3];
   wire [7:0] host_q, dev_q, pins, rd_byte;
   wire [16:0] fail_addr, addr;
   wire [4:0] pulses_used;
   wire cmd_ready, data_need, done, fail, par_ok, oe_n, cs_n, og_n, strobe_n, vpp, idv;
   wire dev_en, misuse;
   int err_count = 0, checked = 0, cyc, pulses, plen;
   // Nothing pulls the pins, so a floating bus shows the inverse of its last driven level
   assign pins = !oe_n ? host_q : (dev_en ? dev_q : ~last_ff);
   always @(posedge clk) begin
      if (!oe_n || dev_en) begin
         last_ff <= pins;
      end
   end
   initial forever #20 clk = ~clk;
   eprom_host dut (.clk(clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_op(cmd_op), .cmd_addr(cmd_addr), .cmd_last(cmd_last), .data_need(data_need),
      .data_valid(data_valid), .data_byte(data_byte), .done(done), .fail(fail),
      .fail_addr(fail_addr), .rd_byte(rd_byte), .id_parity_ok(par_ok),
      .pulses_used(pulses_used), .word_address_bus(addr), .byte_data_pins_out(host_q),
      .byte_data_pins_in(pins), .byte_data_pins_oe_n(oe_n), .chip_select_n(cs_n),
      .output_gate_n(og_n), .program_strobe_n(strobe_n), .program_supply_high(vpp),
      .identify_high_voltage(idv));
   eprom_device_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) mdl (.clk(clk),
      .addr(addr), .din(pins), .cs_n(cs_n), .og_n(og_n), .strobe_n(strobe_n),
      .vpp_high(vpp), .id_high(idv), .dout(dev_q), .dout_en(dev_en), .misuse(misuse));
   // ==========================================================
   // Helpers
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      checked++;
      if (seen !== exp) begin
         err_count++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d, err_count %0d", checked, err_count);
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // Issues one command and serves the byte stream until done
   task automatic run(input logic [1:0] op, input logic [16:0] a, input int span);
      int k, j;
      k = 0;
      cyc = 0;
      pulses = 0;
      plen = 0;
      cmd_op = op;
      cmd_addr = a;
      cmd_last = a + 17'(span - 1);
      cmd_valid = 1'h1;
      @(posedge clk);
      #1 cmd_valid = 1'h0;
      while (done !== 1'h1) begin
         data_valid = data_need;
         data_byte = want[k % span];
         if (data_need === 1'h1) begin
            check(addr, a + 17'(k % span));
            k++;
         end
         j = (k + span - 1) % span;
         check(!oe_n && dev_en, 1'h0);
         if (k > span && og_n === 1'h0) check({vpp, idv}, 2'h0);
         // Pins are looked at one step after the edge, once they have settled
         if (strobe_n === 1'h0) begin
            plen++;
            check({oe_n, cs_n, og_n, vpp, host_q, addr}, {4'h3, want[j], a + 17'(j)});
         end else if (plen != 0) begin
            check(plen, PULSE_CYCLES);
            pulses++;
            plen = 0;
         end
         @(posedge clk);
         #1 cyc++;
         if (cyc > 70000) begin
            err_count++;
            end_sim();
         end
      end
      data_valid = 1'h0;
   endtask
   // ==========================================================
   // Scenarios
   task automatic t_idle();
      check({cmd_ready, cs_n, og_n, strobe_n, oe_n, vpp, idv, done, fail, dev_en}, 10'h3E0);
      $display("idle test done");
   endtask
   task automatic t_read();
      mdl.mem[17'h00055] = 8'hA5;
      run(OP_READ, 17'h00055, 1);
      check({cyc, rd_byte}, {32'(ACCESS_CYCLES + 1), 8'hA5});
      @(posedge clk);
      #1 run(OP_READ, 17'h1FFFF, 1);
      check(rd_byte, 8'hFF);
      $display("read test done");
   endtask
   task automatic t_ident();
      for (int s = 0; s < 2; s++) begin
         @(posedge clk);
         #1 run(OP_IDENT, 17'(s), 1);
         check(rd_byte, s ? DEVICE : MAKER);
         check({par_ok, misuse}, 2'h2);
      end
      $display("identify test done");
   endtask
   task automatic t_prog();
      want = '{8'h5A, 8'h00, 8'hC3};
      @(posedge clk);
      #1 run(OP_PROGRAM, 17'h1FFFD, 3);
      check({fail, pulses_used, pulses}, {1'h0, 5'h1, 32'h5});
      for (int i = 0; i < 3; i++) begin
         check(mdl.mem[17'h1FFFD + i], want[i]);
      end
      $display("program test done");
   endtask
   task automatic t_fail();
      mdl.mem[17'h00010] = 8'h00;
      want[0] = 8'hFF;
      @(posedge clk);
      #1 run(OP_PROGRAM, 17'h00010, 1);
      check({fail, fail_addr, pulses_used}, {1'h1, 17'h00010, 5'h19});
      check(pulses, 32'h19);
      check(mdl.mem[17'h00010], 8'h00);
      $display("give-up test done");
   endtask
   initial begin
      repeat (5) @(posedge clk);
      #1 reset = 1'h0;
      t_idle();
      t_read();
      t_ident();
      t_prog();
      t_fail();
      end_sim();
   end
endmodule // eprom_host_bench
